//--- hdl/ecmcc_core.sv
// Notes on behaviour
// - mask-all bit set boosts execution priority to zero.
// - with secure boost, non-secure mask-all boosts only to 80 hex.
// - exceptions with priority lower or equal to the boost are not activated.
// - without security, fault mask boosts to minus one, only NMI passes.
// - secure fault mask boosts execution priority to minus one.
// - eight-bit threshold boosts when nonzero; zero disables threshold boosting.
// - with secure boost, non-secure threshold maps into the bottom half.
// - unimplemented low threshold bits read zero and drop writes.
// - numerically higher priority value means lower exception priority.
// - secure fp flag is unbanked, zero and unwritable from non-secure state.
// - fp context flag is unbanked and drives fp preservation at entry.
// - banked stack select: zero main stack, one process stack.
// - in handler mode stack select reads zero and drops writes.
// - exception entry clears control bits, exception return updates them from the return code.
// - banked thread privilege bit: zero privileged, one unprivileged.
// - thread uses main stack until written one or suitable return.
// - masks reachable by move instructions; mask bits also by state change.
// - after the barrier, later instructions use the new stack pointer.
// - exceptions other than reset run in handler mode, either state.
// - fault mask also masks some fixed-priority exceptions per configuration.
`default_nettype none

module ecmcc_core
	import ecmcc_pkg::*;
#(
	parameter int PRIO_BITS = 4
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic security_enabled,
	input wire logic secure_priority_boost,
	input wire logic fault_target_nonsecure,
	input wire logic current_secure,
	input wire logic handler_mode,
	input wire logic signed [9:0] handler_priority,
	input wire logic sr_wr_en,
	input wire logic sr_rd_en,
	input wire ecmcc_sel_t sr_sel,
	input wire logic sr_nonsecure_bank,
	input wire logic [31:0] sr_wdata,
	input wire logic cps_en,
	input wire logic cps_fault,
	input wire logic cps_disable,
	input wire logic exc_entry,
	input wire logic exc_entry_secure,
	input wire logic exception_return_code,
	input wire logic [31:0] exception_return_code_code,
	input wire logic fp_instr,
	input wire logic instruction_sync_barrier,
	input wire logic cand_valid,
	input wire logic signed [9:0] cand_priority,
	output logic [31:0] sr_rdata,
	output logic sr_rvalid,
	output logic signed [9:0] exec_priority,
	output logic activate_ok,
	output logic activate_valid,
	output logic use_process_stack,
	output logic thread_unprivileged,
	output logic fp_context_active,
	output logic secure_fp_active
);

	// ---------------------------------------------------------------
	// bank selection
	// ---------------------------------------------------------------
	logic acc_bank; // 1 = non-secure copy
	logic cur_bank;
	logic ret_bank;
	logic ent_bank;
	logic [1:0] pm_q;
	logic [1:0] fm_q;
	logic [7:0] thr_q [2];
	logic [1:0] wr_pm;
	logic [1:0] wr_fm;
	logic [1:0] wr_thr;
	logic [1:0] cps_pm;
	logic [1:0] cps_fm;
	logic wr_ctl;
	logic [1:0] stack_sel_q;
	logic [1:0] unpriv_q;
	logic sec_view;
	logic signed [9:0] boost;
	logic signed [9:0] exec_next;
	logic sync_pend_reg;

	// accesses from non-secure state always reach the non-secure copy
	assign acc_bank = security_enabled & (~current_secure | sr_nonsecure_bank);
	assign cur_bank = security_enabled & ~current_secure;
	assign ret_bank = security_enabled & ~exception_return_code_code[ECMCC_RET_SECURE_BIT];
	assign ent_bank = security_enabled & ~exc_entry_secure;
	assign sec_view = security_enabled & current_secure;
	assign wr_ctl = sr_wr_en & (sr_sel == ECMCC_SEL_CORE_CONTROL);

	// ---------------------------------------------------------------
	// mask and threshold storage
	// ---------------------------------------------------------------
	for (genvar b = 0; b < 2; b++) begin : g_bank
		// write strobes for the copy addressed by the move
		localparam logic BANK = 1'(b);
		assign wr_pm[b] = sr_wr_en & (sr_sel == ECMCC_SEL_MASK_ALL) & (acc_bank == BANK);
		assign wr_fm[b] = sr_wr_en & (sr_sel == ECMCC_SEL_FAULT_MASK) & (acc_bank == BANK);
		assign wr_thr[b] = sr_wr_en & (sr_sel == ECMCC_SEL_BASE_THRESHOLD) & (acc_bank == BANK);
		// state change acts on the copy of the running state
		assign cps_pm[b] = cps_en & ~cps_fault & (cur_bank == BANK);
		assign cps_fm[b] = cps_en & cps_fault & (cur_bank == BANK);
		ecmcc_mask_bit u_mask_all (
			.clock(clock),
			.rst_n(rst_n),
			.wr_en(wr_pm[b]),
			.wr_val(sr_wdata[ECMCC_MASK_BIT]),
			.cps_en(cps_pm[b]),
			.cps_val(cps_disable),
			.mask_q(pm_q[b])
		);
		ecmcc_mask_bit u_fault_mask (
			.clock(clock),
			.rst_n(rst_n),
			.wr_en(wr_fm[b]),
			.wr_val(sr_wdata[ECMCC_MASK_BIT]),
			.cps_en(cps_fm[b]),
			.cps_val(cps_disable),
			.mask_q(fm_q[b])
		);
		ecmcc_base_thr #(
			.PRIO_BITS(PRIO_BITS)
		) u_threshold (
			.clock(clock),
			.rst_n(rst_n),
			.wr_en(wr_thr[b]),
			.wr_data(sr_wdata[ECMCC_THR_MSB:0]),
			.thr_q(thr_q[b])
		);
	end

	// ---------------------------------------------------------------
	// execution priority
	// ---------------------------------------------------------------
	function automatic logic signed [9:0] pmin(input logic signed [9:0] a,
		input logic signed [9:0] c);
		return (a < c) ? a : c;
	endfunction
	// lowest value of all active boosts wins
	always_comb begin
		boost = ECMCC_NO_BOOST;
		if (thr_q[0] != 8'h00) begin
			boost = pmin(boost, $signed({2'h0, thr_q[0]}));
		end
		if (security_enabled && thr_q[1] != 8'h00) begin
			if (secure_priority_boost) begin
				boost = pmin(boost, $signed({2'h0, 1'h1, thr_q[1][7:1]}));
			end else begin
				boost = pmin(boost, $signed({2'h0, thr_q[1]}));
			end
		end
		if (pm_q[0]) begin
			boost = pmin(boost, ECMCC_BOOST_MASK_ALL);
		end
		if (security_enabled && pm_q[1]) begin
			boost = pmin(boost, secure_priority_boost ? ECMCC_BOOST_NS_HALF
				: ECMCC_BOOST_MASK_ALL);
		end
		if (fm_q[0]) begin
			boost = pmin(boost, ECMCC_BOOST_FAULT);
		end
		if (security_enabled && fm_q[1]) begin
			if (fault_target_nonsecure) begin
				boost = pmin(boost, ECMCC_BOOST_FAULT);
			end else begin
				boost = pmin(boost, secure_priority_boost ? ECMCC_BOOST_NS_HALF
					: ECMCC_BOOST_MASK_ALL);
			end
		end
		exec_next = pmin(handler_priority, boost);
	end

	// registered priority and activation verdict
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			exec_priority <= ECMCC_RST_PRIO;
			activate_ok <= 1'h0;
			activate_valid <= 1'h0;
		end else begin
			exec_priority <= exec_next;
			activate_ok <= cand_valid & (cand_priority < exec_next);
			activate_valid <= cand_valid;
		end
	end

	// ---------------------------------------------------------------
	// core control bits
	// ---------------------------------------------------------------
	// stack select: entry clears, return loads, handler writes dropped
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stack_sel_q <= {2{ECMCC_RST_CTL_BIT}};
		end else if (exc_entry) begin
			stack_sel_q[ent_bank] <= 1'h0;
		end else if (exception_return_code) begin
			stack_sel_q[ret_bank] <= exception_return_code_code[ECMCC_RET_STACK_BIT];
		end else if (wr_ctl && !handler_mode) begin
			stack_sel_q[acc_bank] <= sr_wdata[ECMCC_CTL_STACK_BIT];
		end
	end

	// thread privilege, banked
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			unpriv_q <= {2{ECMCC_RST_CTL_BIT}};
		end else if (wr_ctl) begin
			unpriv_q[acc_bank] <= sr_wdata[ECMCC_CTL_UNPRIV_BIT];
		end
	end

	// fp context flag, one copy for both states
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fp_context_active <= ECMCC_RST_CTL_BIT;
		end else if (exc_entry) begin
			fp_context_active <= 1'h0;
		end else if (exception_return_code) begin
			fp_context_active <= ~exception_return_code_code[ECMCC_RET_FTYPE_BIT];
		end else if (fp_instr) begin
			fp_context_active <= 1'h1;
		end else if (wr_ctl) begin
			fp_context_active <= sr_wdata[ECMCC_CTL_FP_CONTEXT_ACTIVE_BIT];
		end
	end

	// secure fp flag, writable from secure state only
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			secure_fp_active <= ECMCC_RST_CTL_BIT;
		end else if (exc_entry) begin
			secure_fp_active <= 1'h0;
		end else if (fp_instr) begin
			secure_fp_active <= sec_view;
		end else if (wr_ctl && sec_view) begin
			secure_fp_active <= sr_wdata[ECMCC_CTL_SECURE_FP_ACTIVE_BIT];
		end
	end

	// ---------------------------------------------------------------
	// stack pointer in use
	// ---------------------------------------------------------------
	// mode change settles one cycle after entry or return
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_pend_reg <= 1'h0;
		end else begin
			sync_pend_reg <= exc_entry | exception_return_code;
		end
	end

	// new stack pointer takes effect only at barrier or mode change
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			use_process_stack <= 1'h0;
		end else if (instruction_sync_barrier || sync_pend_reg) begin
			use_process_stack <= ~handler_mode & stack_sel_q[cur_bank];
		end
	end

	// privilege of the running state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			thread_unprivileged <= 1'h0;
		end else begin
			thread_unprivileged <= unpriv_q[cur_bank];
		end
	end

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	// read data one cycle after the request
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sr_rdata <= 32'h0000_0000;
			sr_rvalid <= 1'h0;
		end else begin
			sr_rvalid <= sr_rd_en;
			if (sr_rd_en) begin
				case (sr_sel)
					ECMCC_SEL_MASK_ALL: sr_rdata <= {31'h0, pm_q[acc_bank]};
					ECMCC_SEL_FAULT_MASK: sr_rdata <= {31'h0, fm_q[acc_bank]};
					ECMCC_SEL_BASE_THRESHOLD: sr_rdata <= {24'h0, thr_q[acc_bank]};
					ECMCC_SEL_CORE_CONTROL: begin
						sr_rdata <= {28'h0, secure_fp_active & sec_view, fp_context_active,
							stack_sel_q[acc_bank] & ~handler_mode, unpriv_q[acc_bank]};
					end
					default: sr_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_mask_all_zero;
		@(posedge clock) disable iff (!rst_n)
		pm_q[0] |=> (exec_priority <= ECMCC_BOOST_MASK_ALL);
	endproperty
	a_mask_all_zero: assert property (p_mask_all_zero)
		else $error("mask-all did not boost priority to zero");
	property p_ns_half;
		@(posedge clock) disable iff (!rst_n)
		(security_enabled && secure_priority_boost && pm_q[1] && !pm_q[0] && fm_q == 2'h0
			&& thr_q[0] == 8'h00 && thr_q[1] == 8'h00 && handler_priority > ECMCC_BOOST_NS_HALF)
		|=> (exec_priority == ECMCC_BOOST_NS_HALF);
	endproperty
	a_ns_half: assert property (p_ns_half)
		else $error("non-secure mask-all boost is not 80 hex");
	property p_refuse;
		@(posedge clock) disable iff (!rst_n)
		(cand_valid && cand_priority >= exec_next) |=> (activate_valid && !activate_ok);
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("masked exception was allowed to activate");
	property p_fault_minus_one;
		@(posedge clock) disable iff (!rst_n)
		fm_q[0] |=> (exec_priority == ECMCC_BOOST_FAULT);
	endproperty
	a_fault_minus_one: assert property (p_fault_minus_one)
		else $error("fault mask did not boost priority to minus one");
	property p_threshold;
		@(posedge clock) disable iff (!rst_n)
		(thr_q[0] != 8'h00) |=> (exec_priority <= $signed({2'h0, $past(thr_q[0])}));
	endproperty
	a_threshold: assert property (p_threshold)
		else $error("threshold did not limit execution priority");
	property p_low_bits;
		@(posedge clock) disable iff (!rst_n)
		sr_rvalid && $past(sr_sel) == ECMCC_SEL_BASE_THRESHOLD
		|-> (sr_rdata[7:0] & ~(8'(8'hff << (ECMCC_THR_W - PRIO_BITS)))) == 8'h00;
	endproperty
	a_low_bits: assert property (p_low_bits)
		else $error("unimplemented threshold bits read nonzero");
	property p_secure_fp_active_ns;
		@(posedge clock) disable iff (!rst_n)
		(wr_ctl && !sec_view && !fp_instr && !exc_entry) |=> $stable(secure_fp_active);
	endproperty
	a_secure_fp_active_ns: assert property (p_secure_fp_active_ns)
		else $error("secure fp flag changed by non-secure write");
	property p_handler_write;
		@(posedge clock) disable iff (!rst_n)
		(wr_ctl && handler_mode && !exc_entry && !exception_return_code) |=> $stable(stack_sel_q);
	endproperty
	a_handler_write: assert property (p_handler_write)
		else $error("stack select written in handler mode");
	property p_entry_fp;
		@(posedge clock) disable iff (!rst_n)
		exc_entry |=> (!fp_context_active && !stack_sel_q[$past(ent_bank)]);
	endproperty
	a_entry_fp: assert property (p_entry_fp)
		else $error("entry did not clear control bits");
	property p_barrier;
		@(posedge clock) disable iff (!rst_n)
		(instruction_sync_barrier && !handler_mode) |=> (use_process_stack == $past(stack_sel_q[cur_bank]));
	endproperty
	a_barrier: assert property (p_barrier)
		else $error("barrier did not apply new stack pointer");
endmodule // ecmcc_core

`default_nettype wire

//--- include/ecmcc_pkg.sv
`default_nettype none

package ecmcc_pkg;

	// ---------------------------------------------------------------
	// special register selection
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ECMCC_SEL_MASK_ALL,
		ECMCC_SEL_FAULT_MASK,
		ECMCC_SEL_BASE_THRESHOLD,
		ECMCC_SEL_CORE_CONTROL
	} ecmcc_sel_t;

	// ---------------------------------------------------------------
	// priority arithmetic
	// ---------------------------------------------------------------
	localparam int ECMCC_PRIO_W = 10;
	localparam logic signed [9:0] ECMCC_NO_BOOST = 10'sh100; // above every level
	localparam logic signed [9:0] ECMCC_BOOST_MASK_ALL = 10'sh000;
	localparam logic signed [9:0] ECMCC_BOOST_NS_HALF = 10'sh080;
	localparam logic signed [9:0] ECMCC_BOOST_FAULT = 10'sh3ff; // minus one
	localparam int ECMCC_THR_W = 8;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int ECMCC_MASK_BIT = 0;
	localparam int ECMCC_THR_MSB = 7;
	localparam int ECMCC_CTL_UNPRIV_BIT = 0;
	localparam int ECMCC_CTL_STACK_BIT = 1;
	localparam int ECMCC_CTL_FP_CONTEXT_ACTIVE_BIT = 2;
	localparam int ECMCC_CTL_SECURE_FP_ACTIVE_BIT = 3;
	localparam int ECMCC_RET_STACK_BIT = 2;
	localparam int ECMCC_RET_FTYPE_BIT = 4;
	localparam int ECMCC_RET_SECURE_BIT = 6;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic ECMCC_RST_MASK = 1'h0;
	localparam logic [7:0] ECMCC_RST_THR = 8'h00;
	localparam logic ECMCC_RST_CTL_BIT = 1'h0;
	localparam logic signed [9:0] ECMCC_RST_PRIO = 10'sh100;

endpackage : ecmcc_pkg

`default_nettype wire

//--- hdl/ecmcc_mask_bit.sv
`default_nettype none

// one banked copy of a single-bit mask, written by move or state change
module ecmcc_mask_bit
	import ecmcc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic wr_val,
	input wire logic cps_en,
	input wire logic cps_val,
	output logic mask_q
);

	// move write and state change both load the bit, state change wins
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= ECMCC_RST_MASK;
		end else if (cps_en) begin
			mask_q <= cps_val;
		end else if (wr_en) begin
			mask_q <= wr_val;
		end
	end

endmodule // ecmcc_mask_bit

`default_nettype wire

//--- hdl/ecmcc_base_thr.sv
`default_nettype none

// one banked copy of the base priority threshold
module ecmcc_base_thr
	import ecmcc_pkg::*;
#(
	parameter int PRIO_BITS = 4
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] thr_q
);

	// only the upper implemented bits are stored
	localparam logic [7:0] KEEP = 8'(8'hff << (ECMCC_THR_W - PRIO_BITS));

	// unimplemented low bits never hold a one
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			thr_q <= ECMCC_RST_THR;
		end else if (wr_en) begin
			thr_q <= wr_data & KEEP;
		end
	end

endmodule // ecmcc_base_thr

`default_nettype wire

//--- verification/ecmcc_core_tb.sv
`default_nettype none

module ecmcc_core_tb;
	import ecmcc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// table row: config, access, expected readback and priority
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sec;
		ecmcc_sel_t sel;
		logic ns;
		logic boost;
		logic [31:0] wdata;
		logic [31:0] rd;
		logic [9:0] prio;
	} ecmcc_row_t;

	localparam ecmcc_row_t ROWS [9] = '{
		'{1'h1, ECMCC_SEL_MASK_ALL, 1'h0, 1'h0, 32'hffffffff, 32'h00000001, 10'h000},
		'{1'h1, ECMCC_SEL_MASK_ALL, 1'h1, 1'h1, 32'h00000001, 32'h00000001, 10'h080},
		'{1'h0, ECMCC_SEL_FAULT_MASK, 1'h0, 1'h0, 32'h00000001, 32'h00000001, 10'h3ff},
		'{1'h1, ECMCC_SEL_FAULT_MASK, 1'h0, 1'h0, 32'hffffffff, 32'h00000001, 10'h3ff},
		'{1'h1, ECMCC_SEL_FAULT_MASK, 1'h1, 1'h1, 32'h00000001, 32'h00000001, 10'h080},
		'{1'h1, ECMCC_SEL_BASE_THRESHOLD, 1'h0, 1'h0, 32'hffffffff, 32'h000000f0, 10'h0f0},
		'{1'h1, ECMCC_SEL_BASE_THRESHOLD, 1'h1, 1'h1, 32'h00000040, 32'h00000040, 10'h0a0},
		'{1'h1, ECMCC_SEL_BASE_THRESHOLD, 1'h0, 1'h0, 32'h00000000, 32'h00000000, 10'h100},
		'{1'h1, ECMCC_SEL_CORE_CONTROL, 1'h0, 1'h0, 32'h00000003, 32'h00000003, 10'h100}
	};

	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic security_enabled = 1'h1;
	logic secure_priority_boost = 1'h0;
	logic fault_target_nonsecure = 1'h0;
	logic current_secure = 1'h1;
	logic handler_mode = 1'h0;
	logic signed [9:0] handler_priority = 10'sh100;
	logic sr_wr_en = 1'h0;
	logic sr_rd_en = 1'h0;
	ecmcc_sel_t sr_sel = ECMCC_SEL_MASK_ALL;
	logic sr_nonsecure_bank = 1'h0;
	logic [31:0] sr_wdata = 32'h00000000;
	logic cps_en = 1'h0;
	logic cps_fault = 1'h0;
	logic cps_disable = 1'h0;
	logic exc_entry = 1'h0;
	logic exc_entry_secure = 1'h1;
	logic exception_return_code = 1'h0;
	logic [31:0] exception_return_code_code = 32'h00000000;
	logic fp_instr = 1'h0;
	logic instruction_sync_barrier = 1'h0;
	logic cand_valid = 1'h0;
	logic signed [9:0] cand_priority = 10'sh000;
	logic [31:0] sr_rdata;
	logic sr_rvalid;
	logic signed [9:0] exec_priority;
	logic activate_ok;
	logic activate_valid;
	logic use_process_stack;
	logic thread_unprivileged;
	logic fp_context_active;
	logic secure_fp_active;
	logic [31:0] q;
	int err_count = 0;
	int check_count = 0;

	ecmcc_core #(.PRIO_BITS(4)) dut (
		.clock(clock), .rst_n(rst_n), .security_enabled(security_enabled),
		.secure_priority_boost(secure_priority_boost),
		.fault_target_nonsecure(fault_target_nonsecure), .current_secure(current_secure),
		.handler_mode(handler_mode), .handler_priority(handler_priority),
		.sr_wr_en(sr_wr_en), .sr_rd_en(sr_rd_en), .sr_sel(sr_sel),
		.sr_nonsecure_bank(sr_nonsecure_bank), .sr_wdata(sr_wdata), .cps_en(cps_en),
		.cps_fault(cps_fault), .cps_disable(cps_disable), .exc_entry(exc_entry),
		.exc_entry_secure(exc_entry_secure), .exception_return_code(exception_return_code),
		.exception_return_code_code(exception_return_code_code), .fp_instr(fp_instr), .instruction_sync_barrier(instruction_sync_barrier),
		.cand_valid(cand_valid), .cand_priority(cand_priority), .sr_rdata(sr_rdata),
		.sr_rvalid(sr_rvalid), .exec_priority(exec_priority), .activate_ok(activate_ok),
		.activate_valid(activate_valid), .use_process_stack(use_process_stack),
		.thread_unprivileged(thread_unprivileged), .fp_context_active(fp_context_active),
		.secure_fp_active(secure_fp_active)
	);

	// clock at 50 ns period
	always #25 clock = ~clock;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk_prio(input logic [9:0] e);
		check("exec_priority", {22'h000000, exec_priority}, {22'h000000, e});
	endtask

	task automatic wr(input ecmcc_sel_t s, input logic ns, input logic [31:0] d);
		@(negedge clock);
		sr_wr_en = 1'h1;
		sr_sel = s;
		sr_nonsecure_bank = ns;
		sr_wdata = d;
		@(negedge clock);
		sr_wr_en = 1'h0;
	endtask

	task automatic rd(input ecmcc_sel_t s, input logic ns);
		@(negedge clock);
		sr_rd_en = 1'h1;
		sr_sel = s;
		sr_nonsecure_bank = ns;
		@(negedge clock);
		sr_rd_en = 1'h0;
		check("sr_rvalid", {31'h00000000, sr_rvalid}, 32'h00000001);
		q = sr_rdata;
	endtask

	task automatic change_processor_state(input logic f, input logic d, input logic [9:0] e);
		@(negedge clock);
		cps_en = 1'h1;
		cps_fault = f;
		cps_disable = d;
		@(negedge clock);
		cps_en = 1'h0;
		@(negedge clock);
		chk_prio(e);
	endtask

	task automatic cand(input logic [9:0] p, input logic ok);
		@(negedge clock);
		cand_valid = 1'h1;
		cand_priority = p;
		@(negedge clock);
		cand_valid = 1'h0;
		check("activate_valid", {31'h00000000, activate_valid}, 32'h00000001);
		check("activate_ok", {31'h00000000, activate_ok}, {31'h00000000, ok});
	endtask

	task automatic pulse_exc(input logic ret, input logic [31:0] code);
		@(negedge clock);
		exc_entry = ~ret;
		exception_return_code = ret;
		exception_return_code_code = code;
		@(negedge clock);
		exc_entry = 1'h0;
		exception_return_code = 1'h0;
		@(negedge clock);
	endtask

	// watchdog, far beyond the length of the sequence
	initial begin
		#(50 * 4000);
		err_count++;
		close_out();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(negedge clock);
		rst_n = 1'h1;
		@(negedge clock);
		chk_prio(10'h100);
		check("control outputs", {28'h0000000, use_process_stack, thread_unprivileged,
			fp_context_active, secure_fp_active}, 32'h00000000);
		for (int i = 0; i < 4; i++) begin
			rd(ecmcc_sel_t'(i), 1'h0);
			check("reset readback", q, 32'h00000000);
		end
		// table of writes, readbacks and boosts
		foreach (ROWS[i]) begin
			@(negedge clock);
			security_enabled = ROWS[i].sec;
			secure_priority_boost = ROWS[i].boost;
			wr(ROWS[i].sel, ROWS[i].ns, ROWS[i].wdata);
			rd(ROWS[i].sel, ROWS[i].ns);
			check("row readback", q, ROWS[i].rd);
			chk_prio(ROWS[i].prio);
			wr(ROWS[i].sel, ROWS[i].ns, 32'h00000000);
		end
		security_enabled = 1'h1;
		secure_priority_boost = 1'h0;
		// non-secure fault mask aimed at non-secure faults boosts to minus one
		fault_target_nonsecure = 1'h1;
		wr(ECMCC_SEL_FAULT_MASK, 1'h1, 32'h00000001);
		@(negedge clock);
		chk_prio(10'h3ff);
		wr(ECMCC_SEL_FAULT_MASK, 1'h1, 32'h00000000);
		fault_target_nonsecure = 1'h0;
		// activation at the threshold boundary
		wr(ECMCC_SEL_BASE_THRESHOLD, 1'h0, 32'h00000040);
		cand(10'h040, 1'h0);
		cand(10'h03f, 1'h1);
		cand(10'h041, 1'h0);
		wr(ECMCC_SEL_BASE_THRESHOLD, 1'h0, 32'h00000000);
		// an active handler alone sets the execution priority
		handler_priority = 10'sh020;
		cand(10'h020, 1'h0);
		chk_prio(10'h020);
		handler_priority = 10'sh100;
		// state change instruction on both mask bits
		change_processor_state(1'h0, 1'h1, 10'h000);
		change_processor_state(1'h1, 1'h1, 10'h3ff);
		change_processor_state(1'h1, 1'h0, 10'h000);
		change_processor_state(1'h0, 1'h0, 10'h100);
		// stack select write dropped in handler mode
		handler_mode = 1'h1;
		wr(ECMCC_SEL_CORE_CONTROL, 1'h0, 32'h00000002);
		rd(ECMCC_SEL_CORE_CONTROL, 1'h0);
		check("handler stack bit", {31'h00000000, q[1]}, 32'h00000000);
		handler_mode = 1'h0;
		rd(ECMCC_SEL_CORE_CONTROL, 1'h0);
		check("thread stack bit", {31'h00000000, q[1]}, 32'h00000000);
		// stack switch takes effect at the barrier
		wr(ECMCC_SEL_CORE_CONTROL, 1'h0, 32'h00000003);
		check("stack before barrier", {31'h00000000, use_process_stack}, 32'h00000000);
		instruction_sync_barrier = 1'h1;
		@(negedge clock);
		instruction_sync_barrier = 1'h0;
		check("stack after barrier", {31'h00000000, use_process_stack}, 32'h00000001);
		check("unprivileged", {31'h00000000, thread_unprivileged}, 32'h00000001);
		// a set stack select still reads zero in handler mode
		handler_mode = 1'h1;
		rd(ECMCC_SEL_CORE_CONTROL, 1'h0);
		check("handler reads stack zero", {31'h00000000, q[1]}, 32'h00000000);
		handler_mode = 1'h0;
		// entry clears, return restores stack select and fp context
		pulse_exc(1'h0, 32'h00000000);
		check("stack after entry", {31'h00000000, use_process_stack}, 32'h00000000);
		pulse_exc(1'h1, 32'h00000044);
		check("stack after return", {31'h00000000, use_process_stack}, 32'h00000001);
		check("fp after return", {31'h00000000, fp_context_active}, 32'h00000001);
		// fp flags set by fp use, secure flag hidden from non-secure state
		pulse_exc(1'h0, 32'h00000000);
		check("fp after entry", {31'h00000000, fp_context_active}, 32'h00000000);
		@(negedge clock);
		fp_instr = 1'h1;
		@(negedge clock);
		fp_instr = 1'h0;
		check("fp flags", {30'h00000000, fp_context_active, secure_fp_active}, 32'h00000003);
		current_secure = 1'h0;
		rd(ECMCC_SEL_CORE_CONTROL, 1'h0);
		check("ns secure fp bit", {31'h00000000, q[3]}, 32'h00000000);
		wr(ECMCC_SEL_CORE_CONTROL, 1'h0, 32'h00000000);
		check("secure fp kept", {31'h00000000, secure_fp_active}, 32'h00000001);
		current_secure = 1'h1;
		// reset in mid-run drops the boost
		wr(ECMCC_SEL_MASK_ALL, 1'h0, 32'h00000001);
		@(negedge clock);
		chk_prio(10'h000);
		rst_n = 1'h0;
		@(negedge clock);
		chk_prio(10'h100);
		rst_n = 1'h1;
		rd(ECMCC_SEL_MASK_ALL, 1'h0);
		check("mask after reset", q, 32'h00000000);
		close_out();
	end

endmodule // ecmcc_core_tb

`default_nettype wire
